// file: rtl/pif_irq_flags.sv
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Enable bits 5,4,3 are unit 2 pulse-width, period, overflow; 1 enables.
// - Enable bits 2,1,0 are unit 1 pulse-width, period, overflow; 1 enables.
// - An overflow requests an interrupt only while its enable bit is one.
// - No capture-timer interrupt reaches the core without the global enable.
// - Timer-zero overflow sets flag bit 5; only a software zero clears it.
// - Flag bit 4 reads one while any per-pin change flag is set.
// - An external-pin event sets flag bit 0.
// - Flags set on their condition whatever the enables say.
// - Flag bit 0 reads zero until an external event since its clear.
module pif_irq_flags
	import pif_pkg::*;
#(
	parameter int N_PIN_FLAGS = pif_pkg::PIF_PIN_FLAGS_DEF
) (
	input wire logic clk_sys, // System clock, 50 MHz
	input wire logic rst_b, // Async reset, active low
	input wire logic [pif_pkg::PIF_ADDR_W-1:0] reg_addr, // Register address
	input wire logic [pif_pkg::PIF_DATA_W-1:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [pif_pkg::PIF_DATA_W-1:0] reg_rdata_ff, // Read data
	input wire logic u1_pulse_width_evt, // Unit 1 pulse-width done
	input wire logic u1_period_evt, // Unit 1 period done
	input wire logic u1_overflow_evt, // Unit 1 counter overflow
	input wire logic u2_pulse_width_evt, // Unit 2 pulse-width done
	input wire logic u2_period_evt, // Unit 2 period done
	input wire logic u2_overflow_evt, // Unit 2 counter overflow
	input wire logic timer_zero_count_ovf, // Timer-zero overflow pulse
	input wire logic ext_pin_evt, // External-pin event pulse
	input wire logic [N_PIN_FLAGS-1:0] per_pin_change_flags, // Pin flags
	output logic irq_ff, // Interrupt request to core
	output logic [pif_pkg::PIF_CT_W-1:0] ct_irq_en_ff, // Enable bits
	output logic peripheral_global_irq_en_ff, // Global enable
	output logic timer_zero_overflow_flag_ff, // Flag bit 5
	output logic any_pin_change_flag_ff, // Flag bit 4, one cycle late
	output logic external_pin_irq_flag_ff // Flag bit 0
);

	import pif_pkg::*;

	generate
		if (N_PIN_FLAGS < 1) begin : g_bad_pins
			$error("N_PIN_FLAGS must be at least one");
		end
	endgenerate

	typedef struct packed {
		logic [PIF_CT_W-1:0] cten;
		logic [PIF_DATA_W-1:0] flgen;
		logic glob;
		logic [PIF_DATA_W-1:0] rdata;
		logic irq;
		logic any_pin;
	} pif_top_s;

	pif_top_s st_ff;
	pif_top_s nxt_st;

	// Bus decode
	logic wr_flag0;
	logic wr_cten;
	logic wr_ctstat;
	logic wr_flgen;
	logic wr_ictl;

	assign wr_flag0 = reg_wr && (reg_addr == PIF_FLAG0_OFS);
	assign wr_cten = reg_wr && (reg_addr == PIF_CTEN_OFS);
	assign wr_ctstat = reg_wr && (reg_addr == PIF_CTSTAT_OFS);
	assign wr_flgen = reg_wr && (reg_addr == PIF_FLGEN_OFS);
	assign wr_ictl = reg_wr && (reg_addr == PIF_ICTL_OFS);

	// Capture-timer event status, cleared by writing ones
	logic [PIF_CT_W-1:0] ct_set;
	logic [PIF_CT_W-1:0] ct_clr;
	logic [PIF_CT_W-1:0] ct_status;

	always_comb begin
		ct_set = '0;
		ct_set[PIF_U2_PW_BIT] = u2_pulse_width_evt;
		ct_set[PIF_U2_PR_BIT] = u2_period_evt;
		ct_set[PIF_U2_OVF_BIT] = u2_overflow_evt;
		ct_set[PIF_U1_PW_BIT] = u1_pulse_width_evt;
		ct_set[PIF_U1_PR_BIT] = u1_period_evt;
		ct_set[PIF_U1_OVF_BIT] = u1_overflow_evt;
	end

	assign ct_clr = wr_ctstat ? reg_wdata[PIF_CT_W-1:0] : '0;

	pif_sticky_bank #(
		.W(PIF_CT_W),
		.RST_VAL(PIF_CTEN_RST)
	) u_ct_bank (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.set_i(ct_set),
		.clr_i(ct_clr),
		.q_ff(ct_status)
	);

	// Flag register: set by hardware, cleared by software writing zero
	logic [PIF_FL_W-1:0] fl_set;
	logic [PIF_FL_W-1:0] fl_clr;
	logic [PIF_FL_W-1:0] fl_q;

	always_comb begin
		fl_set = '0;
		fl_clr = '0;
		fl_set[PIF_FL_TIMER_ZERO_COUNT_IDX] = timer_zero_count_ovf;
		fl_set[PIF_FL_EXT_IDX] = ext_pin_evt;
		// Writing one leaves a flag alone; only a zero acknowledges
		fl_clr[PIF_FL_TIMER_ZERO_COUNT_IDX] = wr_flag0 && !reg_wdata[PIF_TIMER_ZERO_COUNT_BIT];
		fl_clr[PIF_FL_EXT_IDX] = wr_flag0 && !reg_wdata[PIF_EXT_BIT];
	end

	pif_sticky_bank #(
		.W(PIF_FL_W),
		.RST_VAL(PIF_FLAG_RST)
	) u_fl_bank (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.set_i(fl_set),
		.clr_i(fl_clr),
		.q_ff(fl_q)
	);

	// Aggregate of the pin flags; the flag itself cannot be written
	logic ioc_live;

	pif_pin_change_or #(
		.N(N_PIN_FLAGS)
	) u_ioc_or (
		.pin_flags_i(per_pin_change_flags),
		.any_o(ioc_live)
	);

	// Sampled on the system clock; the pins themselves make no clean clock
	a_or_follows: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		ioc_live == (per_pin_change_flags != '0)
	) else $error("pin change aggregate missed a set flag");

	// Views of the registers as software sees them
	logic [PIF_DATA_W-1:0] flag_view;
	logic [PIF_DATA_W-1:0] cten_view;
	logic [PIF_DATA_W-1:0] ctstat_view;
	logic [PIF_DATA_W-1:0] ictl_view;
	logic [PIF_CT_W-1:0] pend_ct;
	logic [PIF_DATA_W-1:0] pend_flag;
	logic [PIF_DATA_W-1:0] pend_view;

	always_comb begin
		flag_view = '0;
		flag_view[PIF_TIMER_ZERO_COUNT_BIT] = fl_q[PIF_FL_TIMER_ZERO_COUNT_IDX];
		flag_view[PIF_IOC_BIT] = ioc_live;
		flag_view[PIF_EXT_BIT] = fl_q[PIF_FL_EXT_IDX];
		cten_view = '0;
		cten_view[PIF_CT_W-1:0] = st_ff.cten;
		ctstat_view = '0;
		ctstat_view[PIF_CT_W-1:0] = ct_status;
		ictl_view = '0;
		ictl_view[PIF_GLOBAL_EN_BIT] = st_ff.glob;
	end

	// Capture sources are peripheral interrupts and need the global enable
	assign pend_ct = ct_status & st_ff.cten;
	assign pend_flag = flag_view & st_ff.flgen;

	always_comb begin
		pend_view = '0;
		pend_view[PIF_CT_W-1:0] = st_ff.glob ? pend_ct : '0;
		pend_view[PIF_DATA_W-1] = |pend_flag;
	end

	always_comb begin
		nxt_st = st_ff;
		if (wr_cten) begin
			// Top two bits have no storage
			nxt_st.cten = reg_wdata[PIF_CT_W-1:0];
		end
		if (wr_flgen) begin
			nxt_st.flgen = reg_wdata;
		end
		if (wr_ictl) begin
			nxt_st.glob = reg_wdata[PIF_GLOBAL_EN_BIT];
		end
		nxt_st.rdata = PIF_RDATA_RST;
		if (reg_rd) begin
			case (reg_addr)
				PIF_FLAG0_OFS: nxt_st.rdata = flag_view;
				PIF_CTEN_OFS: nxt_st.rdata = cten_view;
				PIF_CTSTAT_OFS: nxt_st.rdata = ctstat_view;
				PIF_FLGEN_OFS: nxt_st.rdata = st_ff.flgen;
				PIF_ICTL_OFS: nxt_st.rdata = ictl_view;
				PIF_PEND_OFS: nxt_st.rdata = pend_view;
				default: nxt_st.rdata = PIF_RDATA_RST;
			endcase
		end
		nxt_st.irq = (st_ff.glob && (pend_ct != '0)) || (pend_flag != '0);
		nxt_st.any_pin = ioc_live;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st_ff <= '{cten: PIF_CTEN_RST, flgen: PIF_FLGEN_RST,
				glob: PIF_GLOBAL_EN_RST, rdata: PIF_RDATA_RST,
				irq: 1'b0, any_pin: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign reg_rdata_ff = st_ff.rdata;
	assign irq_ff = st_ff.irq;
	assign ct_irq_en_ff = st_ff.cten;
	assign peripheral_global_irq_en_ff = st_ff.glob;
	assign timer_zero_overflow_flag_ff = fl_q[PIF_FL_TIMER_ZERO_COUNT_IDX];
	assign any_pin_change_flag_ff = st_ff.any_pin;
	assign external_pin_irq_flag_ff = fl_q[PIF_FL_EXT_IDX];

	// Checks
	sequence seq_en_write_readback;
		wr_cten ##1 (reg_rd && reg_addr == PIF_CTEN_OFS && !reg_wr);
	endsequence

	sequence seq_u1_ovf_armed;
		(u1_overflow_evt && st_ff.cten[PIF_U1_OVF_BIT] && st_ff.glob)
		##1 (st_ff.cten[PIF_U1_OVF_BIT] && st_ff.glob);
	endsequence

	sequence seq_timer_zero_count_held;
		timer_zero_overflow_flag_ff
		&& !(wr_flag0 && !reg_wdata[PIF_TIMER_ZERO_COUNT_BIT]);
	endsequence

	a_en_readback: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		seq_en_write_readback |=>
			(reg_rdata_ff[PIF_CT_W-1:0] == $past(reg_wdata[PIF_CT_W-1:0], 2))
	) else $error("enable register did not read back");

	a_en_high_zero: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		(reg_rd && reg_addr == PIF_CTEN_OFS) |=>
			(reg_rdata_ff[PIF_DATA_W-1:PIF_CT_W] == '0)
	) else $error("unimplemented enable bits read nonzero");

	a_ovf_irq_path: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		seq_u1_ovf_armed |=> irq_ff
	) else $error("enabled overflow did not raise interrupt");

	a_ovf_masked: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		(ct_status == 6'h01 && !st_ff.cten[PIF_U1_OVF_BIT]
			&& pend_flag == '0) |=> !irq_ff
	) else $error("disabled overflow raised interrupt");

	a_global_gate: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		(!st_ff.glob && pend_flag == '0) |=> !irq_ff
	) else $error("interrupt passed without global enable");

	a_timer_zero_count_sticky: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		seq_timer_zero_count_held |=> timer_zero_overflow_flag_ff
	) else $error("timer-zero flag dropped without software");

	a_timer_zero_count_set: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		timer_zero_count_ovf |=> timer_zero_overflow_flag_ff
	) else $error("timer-zero overflow not flagged");

	a_ioc_read: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		(reg_rd && reg_addr == PIF_FLAG0_OFS) |=>
			(reg_rdata_ff[PIF_IOC_BIT] == $past(|per_pin_change_flags))
	) else $error("aggregate pin change bit wrong on read");

	a_ext_set: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		ext_pin_evt |=> external_pin_irq_flag_ff
	) else $error("external event not flagged");

	a_ext_quiet: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		(!external_pin_irq_flag_ff && !ext_pin_evt) |=>
			!external_pin_irq_flag_ff
	) else $error("external flag rose with no event");

	a_ct_set_free: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		(u2_period_evt && !st_ff.glob) |=> ct_status[PIF_U2_PR_BIT]
	) else $error("capture event not recorded while disabled");

endmodule // pif_irq_flags

`default_nettype wire

// file: common/pif_pkg.sv
package pif_pkg;

	// Register bus geometry
	localparam int PIF_ADDR_W = 12;
	localparam int PIF_DATA_W = 8;

	// Register offsets
	localparam logic [PIF_ADDR_W-1:0] PIF_FLAG0_OFS = 12'h70c;
	localparam logic [PIF_ADDR_W-1:0] PIF_CTEN_OFS = 12'h71e;
	localparam logic [PIF_ADDR_W-1:0] PIF_CTSTAT_OFS = 12'h71f;
	localparam logic [PIF_ADDR_W-1:0] PIF_FLGEN_OFS = 12'h716;
	localparam logic [PIF_ADDR_W-1:0] PIF_ICTL_OFS = 12'h00b;
	localparam logic [PIF_ADDR_W-1:0] PIF_PEND_OFS = 12'h717;

	// Capture-timer enable and status layout
	localparam int PIF_CT_W = 6;
	localparam int PIF_U2_PW_BIT = 5;
	localparam int PIF_U2_PR_BIT = 4;
	localparam int PIF_U2_OVF_BIT = 3;
	localparam int PIF_U1_PW_BIT = 2;
	localparam int PIF_U1_PR_BIT = 1;
	localparam int PIF_U1_OVF_BIT = 0;

	// Flag register layout
	localparam int PIF_TIMER_ZERO_COUNT_BIT = 5;
	localparam int PIF_IOC_BIT = 4;
	localparam int PIF_EXT_BIT = 0;

	// Sticky flag bank slots for the flag register
	localparam int PIF_FL_W = 2;
	localparam int PIF_FL_TIMER_ZERO_COUNT_IDX = 1;
	localparam int PIF_FL_EXT_IDX = 0;

	// Interrupt control layout
	localparam int PIF_GLOBAL_EN_BIT = 6;

	// Reset values
	localparam logic [PIF_CT_W-1:0] PIF_CTEN_RST = 6'h00;
	localparam logic [PIF_FL_W-1:0] PIF_FLAG_RST = 2'h0;
	localparam logic [PIF_DATA_W-1:0] PIF_FLGEN_RST = 8'h00;
	localparam logic PIF_GLOBAL_EN_RST = 1'b0;
	localparam logic [PIF_DATA_W-1:0] PIF_RDATA_RST = 8'h00;

	// Default count of per-pin change flags (five ports of eight)
	localparam int PIF_PIN_FLAGS_DEF = 40;

endpackage

// file: rtl/pif_sticky_bank.sv
`timescale 1ns/1ps
`default_nettype none

module pif_sticky_bank #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk_sys, // System clock
	input wire logic rst_b, // Async reset, active low
	input wire logic [W-1:0] set_i, // Event pulses, one per flag
	input wire logic [W-1:0] clr_i, // Clear requests, one per flag
	output logic [W-1:0] q_ff // Sticky flags
);

	typedef struct packed {
		logic [W-1:0] q;
	} pif_bank_s;

	pif_bank_s st_ff;
	pif_bank_s nxt_st;
	logic [W-1:0] nxt_bits;

	generate
		if (W < 1) begin : g_bad_w
			$error("pif_sticky_bank needs at least one flag");
		end
	endgenerate

	// Set wins so an event landing on a clear is never lost
	genvar gi;
	generate
		for (gi = 0; gi < W; gi++) begin : g_bit
			assign nxt_bits[gi] = set_i[gi] | (st_ff.q[gi] & ~clr_i[gi]);
		end
	endgenerate

	always_comb begin
		nxt_st = st_ff;
		nxt_st.q = nxt_bits;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st_ff <= '{q: RST_VAL};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign q_ff = st_ff.q;

	a_set_over_clear: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		(set_i != '0) |=> ((q_ff & $past(set_i)) == $past(set_i))
	) else $error("flag event lost against a clear");

endmodule // pif_sticky_bank

`default_nettype wire

// file: rtl/pif_pin_change_or.sv
`timescale 1ns/1ps
`default_nettype none

module pif_pin_change_or #(
	parameter int N = 40
) (
	input wire logic [N-1:0] pin_flags_i, // Per-pin change flags
	output logic any_o // High while any flag is set
);

	logic [N-1:0] chain;

	generate
		if (N < 1) begin : g_bad_n
			$error("pif_pin_change_or needs at least one flag");
		end
	endgenerate

	// Live OR, nothing stored; clearing is done at the pin flags
	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : g_or
			if (gi == 0) begin : g_first
				assign chain[gi] = pin_flags_i[gi];
			end else begin : g_rest
				assign chain[gi] = chain[gi-1] | pin_flags_i[gi];
			end
		end
	endgenerate

	assign any_o = chain[N-1];

endmodule // pif_pin_change_or

`default_nettype wire

// file: sim/pif_pin_src.sv
`timescale 1ns/1ps
`default_nettype none

// Per-pin change detectors plus the firmware that acknowledges them
module pif_pin_src #(
	parameter int N = 40
) (
	input wire logic clk_sys, // System clock
	input wire logic rst_b, // Async reset, active low
	input wire logic [N-1:0] set_mask, // Pins that saw an edge
	input wire logic clr_all, // Firmware clears every pin flag
	output logic [N-1:0] flags_ff // Per-pin change flags
);
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			flags_ff <= '0;
		end else if (clr_all) begin
			// Only way to drop the aggregate bit
			flags_ff <= '0;
		end else begin
			flags_ff <= flags_ff | set_mask;
		end
	end
endmodule // pif_pin_src

`default_nettype wire

// file: sim/pif_irq_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none

module pif_irq_flags_tb;
	import pif_pkg::*;
	localparam int NP = PIF_PIN_FLAGS_DEF;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic [PIF_ADDR_W-1:0] reg_addr = '0;
	logic [PIF_DATA_W-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] evt = '0;
	logic [NP-1:0] pin_set = '0;
	logic pin_clr = 1'b0;
	wire logic [NP-1:0] pin_flags;
	wire logic [PIF_DATA_W-1:0] rdata;
	wire logic irq;
	wire logic [PIF_CT_W-1:0] cten_o;
	wire logic glob_o;
	wire logic timer_zero_count_o;
	wire logic anypin_o;
	wire logic ext_o;
	logic rd_seen = 1'b0;
	logic [7:0] exp_q[$];
	int n_errors = 0;
	int cmp_count = 0;
	integer seed = 62230;
	logic [7:0] rv;
	int pin_idx;

	always #10 clk_sys = ~clk_sys;

	pif_irq_flags #(.N_PIN_FLAGS(NP)) dut (
		.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_ff(rdata),
		.u1_pulse_width_evt(evt[PIF_U1_PW_BIT]),
		.u1_period_evt(evt[PIF_U1_PR_BIT]),
		.u1_overflow_evt(evt[PIF_U1_OVF_BIT]),
		.u2_pulse_width_evt(evt[PIF_U2_PW_BIT]),
		.u2_period_evt(evt[PIF_U2_PR_BIT]),
		.u2_overflow_evt(evt[PIF_U2_OVF_BIT]),
		.timer_zero_count_ovf(evt[6]), .ext_pin_evt(evt[7]),
		.per_pin_change_flags(pin_flags), .irq_ff(irq),
		.ct_irq_en_ff(cten_o), .peripheral_global_irq_en_ff(glob_o),
		.timer_zero_overflow_flag_ff(timer_zero_count_o),
		.any_pin_change_flag_ff(anypin_o),
		.external_pin_irq_flag_ff(ext_o)
	);

	pif_pin_src #(.N(NP)) pins (
		.clk_sys(clk_sys), .rst_b(rst_b), .set_mask(pin_set),
		.clr_all(pin_clr), .flags_ff(pin_flags)
	);

	task automatic check(input string what, input logic [7:0] exp,
		input logic [7:0] seen);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
	endtask

	task automatic fire(input logic [7:0] v);
		@(posedge clk_sys);
		evt <= v;
		@(posedge clk_sys);
		evt <= '0;
	endtask

	// Three edges covers the two-cycle lag, one cycle of it already spent in the task, with two cycles of slack
	task automatic irq_is(input logic e);
		repeat (3) @(posedge clk_sys);
		#1;
		check("irq", {7'h00, e}, {7'h00, irq});
	endtask

	// Level outputs, looked at off the edge
	task automatic outs_are(input logic [5:0] c, input logic [3:0] f);
		#1;
		check("enable out", {2'h0, c}, {2'h0, cten_o});
		check("flag outs", {4'h0, f},
			{4'h0, glob_o, timer_zero_count_o, anypin_o, ext_o});
	endtask

	// Write then read with no gap between the strobes
	task automatic wr_rd(input logic [11:0] a, input logic [7:0] d,
		input logic [7:0] e);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		exp_q.push_back(e);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
	endtask

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Read data stands only in the cycle after the strobe
	always @(posedge clk_sys) rd_seen <= reg_rd;
	always @(negedge clk_sys) begin
		if (rd_seen) begin
			check("read data", exp_q.size() ? exp_q.pop_front() : 8'hxx,
				rdata);
		end
	end

	initial begin
		repeat (20) @(posedge clk_sys);
		rst_b <= 1'b1;
		rd(PIF_CTEN_OFS, 8'h00);
		rd(PIF_FLAG0_OFS, 8'h00);
		$display("test reset done");
		wr(PIF_CTEN_OFS, 8'hff);
		rd(PIF_CTEN_OFS, 8'h3f);
		rv = 8'($random(seed));
		wr_rd(PIF_CTEN_OFS, rv, rv & 8'h3f);
		wr(PIF_CTEN_OFS, 8'h00);
		$display("test enable layout done");
		fire(8'hff);
		rd(PIF_FLAG0_OFS, 8'h21);
		rd(PIF_CTSTAT_OFS, 8'h3f);
		outs_are(6'h00, 4'b0101);
		irq_is(1'b0);
		wr(PIF_CTEN_OFS, 8'h3f);
		irq_is(1'b0);
		wr(PIF_ICTL_OFS, 8'h40);
		irq_is(1'b1);
		outs_are(6'h3f, 4'b1101);
		wr(PIF_CTSTAT_OFS, 8'h3f);
		irq_is(1'b0);
		$display("test global gate done");
		wr(PIF_CTEN_OFS, 8'h08);
		fire(8'h01);
		irq_is(1'b0);
		fire(8'h08);
		irq_is(1'b1);
		wr(PIF_CTSTAT_OFS, 8'h3f);
		irq_is(1'b0);
		$display("test overflow enable done");
		wr(PIF_FLAG0_OFS, 8'hff);
		rd(PIF_FLAG0_OFS, 8'h21);
		wr(PIF_FLAG0_OFS, 8'h00);
		rd(PIF_FLAG0_OFS, 8'h00);
		wr(PIF_FLGEN_OFS, 8'h01);
		fire(8'h80);
		irq_is(1'b1);
		wr(PIF_FLAG0_OFS, 8'h00);
		irq_is(1'b0);
		$display("test flag clear done");
		pin_idx = int'($unsigned($random(seed)) % NP);
		@(posedge clk_sys);
		pin_set <= {{(NP-1){1'b0}}, 1'b1} << pin_idx;
		@(posedge clk_sys);
		pin_set <= '0;
		rd(PIF_FLAG0_OFS, 8'h10);
		irq_is(1'b0);
		outs_are(6'h08, 4'b1010);
		@(posedge clk_sys);
		pin_clr <= 1'b1;
		@(posedge clk_sys);
		pin_clr <= 1'b0;
		rd(PIF_FLAG0_OFS, 8'h00);
		wr(12'h123, 8'hff);
		rd(12'h123, 8'h00);
		rd(PIF_CTEN_OFS, 8'h08);
		outs_are(6'h08, 4'b1000);
		$display("test pin change done");
		repeat (4) @(posedge clk_sys);
		complete_run();
	end

	initial begin
		repeat (5000) @(posedge clk_sys);
		n_errors++;
		complete_run();
	end
endmodule // pif_irq_flags_tb

`default_nettype wire
